// >>> src/sbcu_top.v
// Purpose: skip and conditional relative branch evaluation unit
// Assumes: decoder presents one op per issue pulse, operands valid with it
// Notes: next program counter and busy cycles are registered outputs
`timescale 1ns/1ps
`include "sbcu_regs.vh"
module sbcu_top #(
   parameter PC_W = 16,
   parameter K_W = 7
) (
   // clock and reset
   input wire sys_clk_i,
   input wire nrst_i,
   // decoder side
   input wire issue_i,
   input wire [3:0] op_i,
   input wire [2:0] bit_sel_i,
   input wire [K_W-1:0] offset_k_i,
   input wire next_two_words_i,
   // operands
   input wire [PC_W-1:0] program_counter_i,
   input wire [7:0] source_working_register_i,
   input wire [7:0] io_val_i,
   input wire [7:0] status_flags_register_i,
   // program counter side
   output wire ready_o,
   output reg pc_load_o,
   output reg [PC_W-1:0] pc_next_o,
   output reg taken_o,
   output reg [1:0] cycles_o,
   output reg done_o
);
   localparam ST_IDLE = 1'b0;
   localparam ST_BUSY = 1'b1;

   reg rst_s1_r;
   reg rst_s2_r;
   wire rst_n;
   reg state_r;
   reg [1:0] wait_r;
   wire is_skip;
   wire is_branch;
   wire cond;
   wire [PC_W-1:0] k_ext;
   reg [PC_W-1:0] pc_calc;
   reg [1:0] cyc_calc;

   // two-stage reset release
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   sbcu_cond u_cond (
      .op_i(op_i),
      .bit_sel_i(bit_sel_i),
      .src_reg_i(source_working_register_i),
      .io_val_i(io_val_i),
      .flags_i(status_flags_register_i),
      .is_skip_o(is_skip),
      .is_branch_o(is_branch),
      .cond_o(cond)
   );

   // sign extension; flags are inputs only, never driven back
   assign k_ext = {{(PC_W-K_W){offset_k_i[K_W-1]}}, offset_k_i};

   always @* begin
      pc_calc = program_counter_i + {{(PC_W-2){1'b0}}, `SBCU_STEP_SEQ};
      cyc_calc = `SBCU_CYC_ONE;
      if (is_skip && cond) begin
         if (next_two_words_i) begin
            pc_calc = program_counter_i +
               {{(PC_W-2){1'b0}}, `SBCU_STEP_SKIP2};
            cyc_calc = `SBCU_CYC_THREE;
         end else begin
            pc_calc = program_counter_i +
               {{(PC_W-2){1'b0}}, `SBCU_STEP_SKIP1};
            cyc_calc = `SBCU_CYC_TWO;
         end
      end else if (is_branch && cond) begin
         pc_calc = program_counter_i + k_ext +
            {{(PC_W-2){1'b0}}, `SBCU_STEP_SEQ};
         cyc_calc = `SBCU_CYC_TWO;
      end
   end

   // new ops are refused while a multi-cycle op drains
   assign ready_o = (state_r == ST_IDLE);

   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         wait_r <= 2'h0;
         pc_load_o <= 1'b0;
         pc_next_o <= {PC_W{1'b0}};
         taken_o <= 1'b0;
         cycles_o <= 2'h0;
         done_o <= 1'b0;
      end else begin
         pc_load_o <= 1'b0;
         done_o <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (issue_i && (is_skip || is_branch)) begin
                  pc_load_o <= 1'b1;
                  pc_next_o <= pc_calc;
                  taken_o <= cond;
                  cycles_o <= cyc_calc;
                  if (cyc_calc == `SBCU_CYC_ONE) begin
                     done_o <= 1'b1;
                  end else begin
                     wait_r <= cyc_calc - 2'h1;
                     state_r <= ST_BUSY;
                  end
               end
            end
            ST_BUSY: begin
               // hold busy so the op spans exactly its cycle count
               if (wait_r == 2'h1) begin
                  done_o <= 1'b1;
                  state_r <= ST_IDLE;
               end
               wait_r <= wait_r - 2'h1;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // sbcu_top

// >>> src/sbcu_regs.vh
// Purpose: constants for the skip and branch condition unit
// Assumes: one program word per fetch slot, word-addressed program counter
// Notes: operation codes are supplied already decoded by the decoder
`ifndef SBCU_REGS_VH
`define SBCU_REGS_VH

// operation select codes
`define SBCU_OP_NONE       4'h0
`define SBCU_OP_SKIP_RCLR  4'h1
`define SBCU_OP_SKIP_RSET  4'h2
`define SBCU_OP_SKIP_IOCLR 4'h3
`define SBCU_OP_SKIP_IOSET 4'h4
`define SBCU_OP_BR_FSET    4'h5
`define SBCU_OP_BR_FCLR    4'h6
`define SBCU_OP_BR_EQ      4'h7
`define SBCU_OP_BR_NE      4'h8
`define SBCU_OP_BR_CS      4'h9
`define SBCU_OP_BR_CC      4'ha
`define SBCU_OP_BR_SH      4'hb
`define SBCU_OP_BR_LO      4'hc
`define SBCU_OP_BR_MI      4'hd

// status flag bit positions
`define SBCU_FLAG_C 3'h0
`define SBCU_FLAG_Z 3'h1
`define SBCU_FLAG_N 3'h2

// program counter step sizes
`define SBCU_STEP_SEQ   2'h1
`define SBCU_STEP_SKIP1 2'h2
`define SBCU_STEP_SKIP2 2'h3

// cycle counts
`define SBCU_CYC_ONE   2'h1
`define SBCU_CYC_TWO   2'h2
`define SBCU_CYC_THREE 2'h3

`endif

// >>> src/sbcu_cond.v
// Purpose: combinational condition evaluation for skip and branch ops
// Assumes: op code and selected bits are stable while issue_i is high
// Notes: pure logic; status flags are only read, never written
`timescale 1ns/1ps
`include "sbcu_regs.vh"
module sbcu_cond (
   // operation
   input wire [3:0] op_i,
   input wire [2:0] bit_sel_i,
   // operands
   input wire [7:0] src_reg_i,
   input wire [7:0] io_val_i,
   input wire [7:0] flags_i,
   // result
   output reg is_skip_o,
   output reg is_branch_o,
   output reg cond_o
);
   wire reg_bit;
   wire io_bit;
   wire flag_bit;
   assign reg_bit = src_reg_i[bit_sel_i];
   assign io_bit = io_val_i[bit_sel_i];
   assign flag_bit = flags_i[bit_sel_i];

   always @* begin
      is_skip_o = 1'b0;
      is_branch_o = 1'b0;
      cond_o = 1'b0;
      case (op_i)
         `SBCU_OP_SKIP_RCLR: begin
            is_skip_o = 1'b1;
            cond_o = ~reg_bit;
         end
         `SBCU_OP_SKIP_RSET: begin
            is_skip_o = 1'b1;
            cond_o = reg_bit;
         end
         `SBCU_OP_SKIP_IOCLR: begin
            is_skip_o = 1'b1;
            cond_o = ~io_bit;
         end
         `SBCU_OP_SKIP_IOSET: begin
            is_skip_o = 1'b1;
            cond_o = io_bit;
         end
         `SBCU_OP_BR_FSET: begin
            is_branch_o = 1'b1;
            cond_o = flag_bit;
         end
         `SBCU_OP_BR_FCLR: begin
            is_branch_o = 1'b1;
            cond_o = ~flag_bit;
         end
         `SBCU_OP_BR_EQ: begin
            is_branch_o = 1'b1;
            cond_o = flags_i[`SBCU_FLAG_Z];
         end
         `SBCU_OP_BR_NE: begin
            is_branch_o = 1'b1;
            cond_o = ~flags_i[`SBCU_FLAG_Z];
         end
         `SBCU_OP_BR_CS: begin
            is_branch_o = 1'b1;
            cond_o = flags_i[`SBCU_FLAG_C];
         end
         `SBCU_OP_BR_CC: begin
            is_branch_o = 1'b1;
            cond_o = ~flags_i[`SBCU_FLAG_C];
         end
         `SBCU_OP_BR_SH: begin
            is_branch_o = 1'b1;
            cond_o = ~flags_i[`SBCU_FLAG_C];
         end
         `SBCU_OP_BR_LO: begin
            is_branch_o = 1'b1;
            cond_o = flags_i[`SBCU_FLAG_C];
         end
         `SBCU_OP_BR_MI: begin
            is_branch_o = 1'b1;
            cond_o = flags_i[`SBCU_FLAG_N];
         end
         default: begin
            is_skip_o = 1'b0;
         end
      endcase
   end
endmodule // sbcu_cond

// >>> test/sbcu_checker.sv
// Purpose: port checks of sbcu_top
// Assumes: one clock, reset low at start
// Notes: issue only counts while ready_o is high
`timescale 1ns/1ps
`include "sbcu_regs.vh"
module sbcu_checker #(parameter PC_W = 16) (
   input wire sys_clk_i, nrst_i, issue_i, next_two_words_i,
   input wire [3:0] op_i,
   input wire [PC_W-1:0] program_counter_i, pc_next_o,
   input wire [7:0] status_flags_register_i,
   input wire ready_o, pc_load_o, taken_o, done_o,
   input wire [1:0] cycles_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence iss;
      issue_i && ready_o && op_i != 4'h0 && op_i < 4'he;
   endsequence
   sequence gap2;
      !done_o ##1 !done_o;
   endsequence
   load_next_a: assert property (iss |=> pc_load_o)
      else $error("no load after issue");
   one_cyc_a: assert property (pc_load_o && cycles_o == 2'h1 |-> done_o)
      else $error("short op not done");
   two_cyc_a: assert property (pc_load_o && cycles_o == 2'h2 |->
      !done_o && !ready_o ##1 done_o) else $error("two cycle timing");
   three_cyc_a: assert property (pc_load_o && cycles_o == 2'h3 |->
      gap2 ##1 done_o) else $error("three cycle timing");
   seq_step_a: assert property (pc_load_o && !taken_o |->
      cycles_o == 2'h1 && pc_next_o == $past(program_counter_i) + 1'b1)
      else $error("not taken step");
   skip_len_a: assert property (iss ##0 op_i < 4'h5 |=> !taken_o ||
      cycles_o == 2'h2 + $past(next_two_words_i)) else $error("skip len");
   br_cyc_a: assert property (iss ##0 op_i > 4'h4 |=>
      cycles_o == (taken_o ? 2'h2 : 2'h1)) else $error("branch cycles");
   eq_cond_a: assert property (iss ##0 op_i == `SBCU_OP_BR_EQ |=>
      taken_o == $past(status_flags_register_i[1])) else $error("eq cond");
endmodule // sbcu_checker
bind sbcu_top sbcu_checker #(.PC_W(PC_W)) u_sbcu_checker (.*);

// >>> test/sbcu_pc_model.sv
// Purpose: program counter fed by the unit's load pulse
// Assumes: load pulse one cycle wide
// Notes: start address is arbitrary
`timescale 1ns/1ps
module sbcu_pc_model #(parameter PC_W = 16, parameter START = 16'h0100) (
   input wire sys_clk_i,
   input wire nrst_i,
   input wire pc_load_i,
   input wire [PC_W-1:0] pc_next_i,
   output logic [PC_W-1:0] pc_o
);
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) pc_o <= START;
      else if (pc_load_i) pc_o <= pc_next_i;
   end
endmodule // sbcu_pc_model

// >>> test/skip_branch_condition_unit_tb_top.sv
// Purpose: self-checking bench for sbcu_top
// Assumes: pc model feeds program_counter_i
// Notes: expectations come from bit and flag tables
`timescale 1ns/1ps
module skip_branch_condition_unit_tb_top;
   logic clk = 1'b0, nrst = 1'b0, iss = 1'b0, two = 1'b0;
   logic [3:0] op = 4'h0;
   logic [2:0] bsel = 3'h5;
   logic [6:0] k = 7'h00;
   logic [7:0] rr = 8'h00, io = 8'h00, fl = 8'h00;
   wire [15:0] pc, pcn;
   wire rdy, ld, tk, dn;
   wire [1:0] cyc;
   int fail_count = 0, num_checks = 0, tmo = 0;
   sbcu_top u_sbcu_top (.sys_clk_i(clk), .nrst_i(nrst), .issue_i(iss),
      .op_i(op), .bit_sel_i(bsel), .offset_k_i(k), .next_two_words_i(two),
      .program_counter_i(pc), .source_working_register_i(rr),
      .io_val_i(io), .status_flags_register_i(fl), .ready_o(rdy),
      .pc_load_o(ld), .pc_next_o(pcn), .taken_o(tk), .cycles_o(cyc),
      .done_o(dn));
   sbcu_pc_model u_sbcu_pc_model (.sys_clk_i(clk), .nrst_i(nrst),
      .pc_load_i(ld), .pc_next_i(pcn), .pc_o(pc));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) if (++tmo == 1000) begin
      fail_count++;
      finish_test();
   end
   task automatic chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // one op: expected pc step d and cycle count ec
   task automatic run(input logic [3:0] o, input logic t,
         input logic [15:0] d, input logic [1:0] ec);
      logic [15:0] p, n;
      @(posedge clk) #1;
      p = pc;
      op = o;
      iss = 1'b1;
      @(posedge clk) #1;
      iss = 1'b0;
      n = 16'h1;
      chk(ld, 1'b1);
      chk(tk, t);
      chk(pcn, p + d);
      chk(cyc, ec);
      chk(rdy, ec == 2'h1);
      while (dn !== 1'b1 && n < 16'h4) begin
         @(posedge clk) #1;
         n++;
      end
      chk(n, ec);
   endtask
   task automatic t_skips();
      logic b;
      bsel = 3'h5;
      for (int o = 1; o < 5; o++)
         for (int v = 0; v < 4; v++) begin
            rr = v[0] ? 8'h20 : 8'hdf;
            io = ~rr;
            two = v[1];
            b = (o < 3 ? rr[5] : io[5]) == !o[0];
            run(4'(o), b, b ? 16'h2 + two : 16'h1,
               b ? 2'h2 + two : 2'h1);
         end
   endtask
   task automatic t_branches();
      logic b;
      bsel = 3'h3;
      for (int o = 5; o < 14; o++)
         for (int v = 0; v < 2; v++) begin
            fl = v ? 8'hf5 : 8'h0a;
            k = v ? 7'h7e : 7'h05;
            b = (o < 7 ? fl[3] : o < 9 ? fl[1] : o < 13 ? fl[0] : fl[2])
               == (o == 5 || o == 7 || o == 9 || o > 11);
            run(4'(o), b, b ? {{9{k[6]}}, k} + 16'h1 : 16'h1,
               b ? 2'h2 : 2'h1);
            // offsets of both signs
         end
   endtask
   // unknown op must leave the outputs quiet
   task automatic t_unknown();
      @(posedge clk) #1;
      op = 4'hf;
      iss = 1'b1;
      @(posedge clk) #1;
      iss = 1'b0;
      repeat (3) begin
         chk(ld | dn, 1'b0);
         @(posedge clk) #1;
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk);
      t_skips();
      t_branches();
      t_unknown();
      finish_test();
   end
endmodule // skip_branch_condition_unit_tb_top
